// *** verilog/arc_regs.svh ***
// constants for the amplifier reset and fault control block
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH

// clock rate
`define ARC_CLK_HZ 200000000
// fault hold before restart (other party), in ms
`define ARC_FAULT_HOLD_MS 4
// start-up settle time in us, and its cycle count
`define ARC_STARTUP_US 10
`define ARC_STARTUP_CYC ((`ARC_STARTUP_US * (`ARC_CLK_HZ / 1000000)))
// short check step time in us, and its cycle count
`define ARC_SHORT_STEP_US 5
`define ARC_SHORT_STEP_CYC ((`ARC_SHORT_STEP_US * (`ARC_CLK_HZ / 1000000)))
// ready filter length in cycles
`define ARC_READY_FILT_CYC 16
// nominal and low switching-rate dividers (half periods)
`define ARC_DIV_NOMINAL 16'h00FA
`define ARC_DIV_LOW 16'h0113
// number of half-bridges
`define ARC_NUM_HB 4
// counter width
`define ARC_CNT_W 16

`endif

// *** verilog/arc_pkg.sv ***
// types for the amplifier reset and fault control block
package arc_pkg;
    // main sequencer states
    typedef enum logic [2:0] {
        ARC_HELD,
        ARC_SHORT_GND,
        ARC_SHORT_PVDD,
        ARC_STARTUP,
        ARC_RUN,
        ARC_FAULT
    } arc_state_t;

    // output configuration
    typedef enum logic [1:0] {
        ARC_MODE_BRIDGE,
        ARC_MODE_PARALLEL,
        ARC_MODE_SINGLE
    } arc_mode_t;
endpackage

// *** verilog/arc_sync_edge.sv ***
// reset input synchroniser with rising-edge detect
`timescale 1ns/1ps
`default_nettype none
module arc_sync_edge
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output logic level,
    output logic rise
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // two flops, then a third for the edge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~prev_ff;
endmodule // arc_sync_edge
`default_nettype wire

// *** verilog/arc_osc.sv ***
// switching oscillator, master or slaved to an external clock
`timescale 1ns/1ps
`default_nettype none
`include "arc_regs.svh"
module arc_osc
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slaveMode,
    input wire logic lowFreqSel,
    input wire logic extClkIn,
    output logic swTick,
    output logic oscOut
);
    logic [`ARC_CNT_W-1:0] divCnt_ff;
    logic osc_ff;
    logic extPrev_ff;
    logic [`ARC_CNT_W-1:0] halfPer;

    // divider selected by the trim setting
    assign halfPer = lowFreqSel ? `ARC_DIV_LOW : `ARC_DIV_NOMINAL;

    // own oscillator, stopped in slave mode
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divCnt_ff <= '0;
            osc_ff <= 1'b0;
        end
        else if (slaveMode)
        begin
            divCnt_ff <= '0;
            osc_ff <= 1'b0;
        end
        else if (divCnt_ff >= halfPer - 16'h0001)
        begin
            divCnt_ff <= '0;
            osc_ff <= ~osc_ff;
        end
        else
        begin
            divCnt_ff <= divCnt_ff + 16'h0001;
        end
    end

    // external clock edge history
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            extPrev_ff <= 1'b0;
        else
            extPrev_ff <= extClkIn;
    end

    assign oscOut = osc_ff;
    assign swTick = slaveMode ? (extClkIn & ~extPrev_ff)
                              : (!osc_ff && divCnt_ff >= halfPer - 16'h0001);
endmodule // arc_osc
`default_nettype wire

// *** verilog/arc_reset_fault_ctrl.sv ***
// reset, fault signalling and start-up control for the power stage
//
// How it works
// - While reset is low every half-bridge transistor is held off (hi-Z).
// - In bridge-tied modes a weak pulldown is applied while reset is low.
// - In single-ended mode outputs stay hi-Z with no pulldown in reset.
// - While reset is low the fault output is released high.
// - After an overload shutdown only a reset rising edge restarts.
// - A reset rising edge runs the start-up sequence, then switching.
// - Ready drops on any overcurrent event; a filtered copy is given.
// - Clip output follows the near-clipping indication while running.
// - Trim tied to the regulator stops the oscillator and slaves it.
// - In master mode the trim resistor selects the switching rate.
// - A thermal shutdown stays latched with hi-Z until reset.
// - During the start-up short check the fault output is low and
//       reset low is ignored.
// - Any shutdown fault drives the open-drain fault output low.
`timescale 1ns/1ps
`default_nettype none
`include "arc_regs.svh"
module arc_reset_fault_ctrl
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reset_n_pin,
    input wire arc_pkg::arc_mode_t outMode,
    input wire logic trimToRegulator,
    input wire logic trimLowFreq,
    input wire logic oscSyncIn,
    input wire logic overloadEvt,
    input wire logic overcurrentEvt,
    input wire logic thermalEvt,
    input wire logic undervoltage,
    input wire logic shortGndDet,
    input wire logic shortPvddDet,
    input wire logic clipDet,
    output logic [`ARC_NUM_HB-1:0] hbHighOn,
    output logic [`ARC_NUM_HB-1:0] hbLowOn,
    output logic [`ARC_NUM_HB-1:0] hbPulldown,
    output logic faultShutdownOut,
    output logic faultShutdownOe,
    output logic readyOut,
    output logic readyFiltOut,
    output logic clipOut,
    output logic oscSyncOut,
    output logic oscSyncOe,
    output logic switching,
    output logic shortCheckBusy
);
    import arc_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    arc_state_t state_ff;
    arc_state_t nxt_state;
    logic [`ARC_CNT_W-1:0] cnt_ff;
    logic [`ARC_CNT_W-1:0] nxt_cnt;
    logic thermalLatch_ff;
    logic overloadLatch_ff;
    logic shortDone_ff;
    logic [4:0] readyCnt_ff;
    logic rstLevel;
    logic rstRise;
    logic swTick;
    logic oscRaw;
    logic inReset;
    logic anyFault;
    logic bridgeMode;
    logic pwm_ff;

    // ----------------------------------------------------------------
    // reset input and oscillator
    // ----------------------------------------------------------------
    // reset pin through two flops before any use
    arc_sync_edge u_rst_sync
    (
        .clk(clk),
        .arst_n(arst_n),
        .din(reset_n_pin),
        .level(rstLevel),
        .rise(rstRise)
    );

    arc_osc u_osc
    (
        .clk(clk),
        .arst_n(arst_n),
        .slaveMode(trimToRegulator),
        .lowFreqSel(trimLowFreq),
        .extClkIn(oscSyncIn),
        .swTick(swTick),
        .oscOut(oscRaw)
    );

    // ----------------------------------------------------------------
    // fault decode
    // ----------------------------------------------------------------
    // short check states ignore reset low; a reset rising edge still clears the overload latch
    assign inReset = !rstLevel && state_ff != ARC_SHORT_GND
                     && state_ff != ARC_SHORT_PVDD;
    assign anyFault = thermalLatch_ff | overloadLatch_ff | undervoltage;
    assign bridgeMode = outMode != ARC_MODE_SINGLE;

    // thermal latch, cleared only by reset low; set wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            thermalLatch_ff <= 1'b0;
        else if (thermalEvt)
            thermalLatch_ff <= 1'b1;
        else if (inReset)
            thermalLatch_ff <= 1'b0;
    end

    // overload latch, cleared only by a reset rising edge; set wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            overloadLatch_ff <= 1'b0;
        else if (overloadEvt)
            overloadLatch_ff <= 1'b1;
        else if (rstRise)
            overloadLatch_ff <= 1'b0;
    end

    // short check done once, not rerun by a device reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            shortDone_ff <= 1'b0;
        else if (state_ff == ARC_SHORT_PVDD && nxt_state == ARC_STARTUP)
            shortDone_ff <= 1'b1;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // next state and counter
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            ARC_HELD:
            begin
                nxt_cnt = '0;
                if (rstRise && !thermalLatch_ff)
                begin
                    if (bridgeMode && !shortDone_ff)
                        nxt_state = ARC_SHORT_GND;
                    else
                        nxt_state = ARC_STARTUP;
                end
            end
            ARC_SHORT_GND:
            begin
                if (shortGndDet)
                    nxt_cnt = '0;
                else if (cnt_ff >= 16'(`ARC_SHORT_STEP_CYC - 1))
                begin
                    nxt_cnt = '0;
                    nxt_state = ARC_SHORT_PVDD;
                end
                else
                    nxt_cnt = cnt_ff + 16'h0001;
            end
            ARC_SHORT_PVDD:
            begin
                if (shortPvddDet)
                    nxt_cnt = '0;
                else if (cnt_ff >= 16'(`ARC_SHORT_STEP_CYC - 1))
                begin
                    nxt_cnt = '0;
                    nxt_state = ARC_STARTUP;
                end
                else
                    nxt_cnt = cnt_ff + 16'h0001;
            end
            ARC_STARTUP:
            begin
                if (inReset)
                    nxt_state = ARC_HELD;
                else if (anyFault)
                    nxt_state = ARC_FAULT;
                else if (cnt_ff >= 16'(`ARC_STARTUP_CYC - 1))
                    nxt_state = ARC_RUN;
                else
                    nxt_cnt = cnt_ff + 16'h0001;
            end
            ARC_RUN:
            begin
                if (inReset)
                    nxt_state = ARC_HELD;
                else if (anyFault)
                    nxt_state = ARC_FAULT;
            end
            ARC_FAULT:
            begin
                if (inReset)
                    nxt_state = ARC_HELD;
                else if (!anyFault)
                begin
                    nxt_cnt = '0;
                    nxt_state = ARC_STARTUP; // undervoltage self-recovers
                end
            end
            default:
                nxt_state = ARC_HELD;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= ARC_HELD;
            cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------------------------------
    // power stage drive
    // ----------------------------------------------------------------
    // pwm phase advances on each switching tick
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pwm_ff <= 1'b0;
        else if (nxt_state != ARC_RUN)
            pwm_ff <= 1'b0;
        else if (swTick)
            pwm_ff <= ~pwm_ff;
    end

    // gates off outside run; pulldown only in bridge modes while held
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hbHighOn <= '0;
            hbLowOn <= '0;
            hbPulldown <= '0;
            switching <= 1'b0;
        end
        else
        begin
            switching <= nxt_state == ARC_RUN;
            if (nxt_state == ARC_RUN)
            begin
                hbHighOn <= {`ARC_NUM_HB{swTick ? ~pwm_ff : pwm_ff}};
                hbLowOn <= {`ARC_NUM_HB{swTick ? pwm_ff : ~pwm_ff}};
            end
            else
            begin
                hbHighOn <= '0;
                hbLowOn <= '0;
            end
            hbPulldown <= {`ARC_NUM_HB{nxt_state == ARC_HELD
                                      && bridgeMode}};
        end
    end

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    // open drain: enable pulls low, released reads high
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            faultShutdownOut <= 1'b0;
            faultShutdownOe <= 1'b0;
            shortCheckBusy <= 1'b0;
        end
        else
        begin
            faultShutdownOut <= 1'b0;
            shortCheckBusy <= nxt_state == ARC_SHORT_GND
                              || nxt_state == ARC_SHORT_PVDD;
            if (nxt_state == ARC_SHORT_GND || nxt_state == ARC_SHORT_PVDD)
                faultShutdownOe <= 1'b1;
            else if (nxt_state == ARC_HELD)
                faultShutdownOe <= 1'b0;
            else
                faultShutdownOe <= nxt_state == ARC_FAULT;
        end
    end

    // ready raw and filtered, clip registered
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            readyOut <= 1'b0;
            readyFiltOut <= 1'b0;
            readyCnt_ff <= '0;
            clipOut <= 1'b0;
        end
        else
        begin
            readyOut <= nxt_state == ARC_RUN && !overcurrentEvt;
            if (nxt_state != ARC_RUN || overcurrentEvt)
            begin
                readyCnt_ff <= '0;
                readyFiltOut <= 1'b0;
            end
            else if (readyCnt_ff >= 5'(`ARC_READY_FILT_CYC - 1))
                readyFiltOut <= 1'b1;
            else
                readyCnt_ff <= readyCnt_ff + 5'h01;
            clipOut <= clipDet && state_ff == ARC_RUN;
        end
    end

    // sync pins driven in master mode, inputs in slave mode
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            oscSyncOut <= 1'b0;
            oscSyncOe <= 1'b0;
        end
        else
        begin
            oscSyncOut <= oscRaw;
            oscSyncOe <= !trimToRegulator;
        end
    end
endmodule // arc_reset_fault_ctrl
`default_nettype wire

// *** sim/arc_rfc_checker.sv ***
// assertion checker for the reset and fault control block
`timescale 1ns/1ps
`default_nettype none
`include "arc_regs.svh"
module arc_rfc_checker
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reset_n_pin,
    input wire arc_pkg::arc_mode_t outMode,
    input wire logic trimToRegulator,
    input wire logic overloadEvt,
    input wire logic overcurrentEvt,
    input wire logic thermalEvt,
    input wire logic clipDet,
    input wire logic [`ARC_NUM_HB-1:0] hbHighOn,
    input wire logic [`ARC_NUM_HB-1:0] hbLowOn,
    input wire logic [`ARC_NUM_HB-1:0] hbPulldown,
    input wire logic faultShutdownOe,
    input wire logic readyOut,
    input wire logic clipOut,
    input wire logic oscSyncOe,
    input wire logic switching,
    input wire logic shortCheckBusy
);
    import arc_pkg::*;
    logic shutLatch_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // shutdown latch as seen from the pins, cleared by reset low
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            shutLatch_ff <= 1'b0;
        else if (!reset_n_pin)
            shutLatch_ff <= 1'b0;
        else if ((thermalEvt || overloadEvt) && switching)
            shutLatch_ff <= 1'b1;
    // reset held: gates off, pulldown by mode, fault released
    property p_hiz;
        (!reset_n_pin)[*6] ##0 !shortCheckBusy |-> !(|{hbHighOn, hbLowOn});
    endproperty
    property p_pdn;
        (!reset_n_pin)[*6] ##0 (!shortCheckBusy && outMode != ARC_MODE_SINGLE
            && $stable(outMode)) |-> hbPulldown == '1;
    endproperty
    property p_se;
        (!reset_n_pin)[*6] ##0 (outMode == ARC_MODE_SINGLE && $stable(outMode))
            |-> hbPulldown == '0;
    endproperty
    property p_sdrel;
        (!reset_n_pin)[*6] ##0 !shortCheckBusy |-> !faultShutdownOe;
    endproperty
    // fault signalling and latches
    property p_chk;
        shortCheckBusy |-> faultShutdownOe;
    endproperty
    property p_flt;
        thermalEvt && switching |-> ##[1:3]
            (faultShutdownOe && !(|{hbHighOn, hbLowOn}));
    endproperty
    property p_lat;
        shutLatch_ff && reset_n_pin[*3] |-> !switching;
    endproperty
    // status outputs and oscillator pins
    property p_rdy;
        overcurrentEvt && switching |-> ##[1:2] !readyOut;
    endproperty
    property p_clip;
        switching && clipDet ##1 switching |-> clipOut;
    endproperty
    property p_slv;
        trimToRegulator[*3] |-> !oscSyncOe;
    endproperty
    property p_mst;
        (!trimToRegulator)[*3] |-> oscSyncOe;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("gates on while reset low");
    a_pdn: assert property (p_pdn)
        else $error("no pulldown in bridge mode reset");
    a_se: assert property (p_se)
        else $error("pulldown in single-ended reset");
    a_sdrel: assert property (p_sdrel)
        else $error("fault pin held while reset low");
    a_chk: assert property (p_chk)
        else $error("fault pin released during short check");
    a_flt: assert property (p_flt)
        else $error("thermal fault not signalled");
    a_lat: assert property (p_lat)
        else $error("restart without reset");
    a_rdy: assert property (p_rdy)
        else $error("ready high on overcurrent");
    a_clip: assert property (p_clip)
        else $error("clip not shown");
    a_slv: assert property (p_slv)
        else $error("sync pin driven in slave mode");
    a_mst: assert property (p_mst)
        else $error("sync pin idle in master mode");
    c_chkEnd: cover property (shortCheckBusy ##1 !shortCheckBusy);
    c_run: cover property ($rose(switching));
    c_therm: cover property (thermalEvt && switching);
endmodule // arc_rfc_checker
bind arc_reset_fault_ctrl arc_rfc_checker u_chk (.clk(clk), .arst_n(arst_n),
    .reset_n_pin(reset_n_pin), .outMode(outMode),
    .trimToRegulator(trimToRegulator), .overloadEvt(overloadEvt),
    .overcurrentEvt(overcurrentEvt), .thermalEvt(thermalEvt),
    .clipDet(clipDet), .hbHighOn(hbHighOn), .hbLowOn(hbLowOn),
    .hbPulldown(hbPulldown), .faultShutdownOe(faultShutdownOe),
    .readyOut(readyOut), .clipOut(clipOut), .oscSyncOe(oscSyncOe),
    .switching(switching), .shortCheckBusy(shortCheckBusy));
`default_nettype wire

// *** sim/arc_ctrl_model.sv ***
// system controller model driving the device reset pin
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_model
#(
    parameter int HOLD = 800000 // 4 ms of 5 ns cycles
)
(
    input wire logic clk,
    input wire logic faultOe,
    input wire logic wantRun,
    output logic pinN
);
    int cnt = 0;
    logic oeLast = 1'b0;
    initial pinN = 1'b0;
    // reset is released only once the fault hold has run out
    always @(posedge clk)
    begin
        oeLast <= faultOe;
        if (faultOe && !oeLast)
            cnt <= 0;
        else if (cnt < HOLD)
            cnt <= cnt + 1;
        pinN <= wantRun && (pinN || cnt >= HOLD);
    end
endmodule // arc_ctrl_model
`default_nettype wire

// *** sim/arc_reset_fault_ctrl_bench.sv ***
// testbench for the reset and fault control block
`timescale 1ns/1ps
`default_nettype none
`include "arc_regs.svh"
module arc_reset_fault_ctrl_bench;
    import arc_pkg::*;
    localparam int HOLD = 64;
    arc_mode_t outMode = ARC_MODE_BRIDGE;
    logic clk = 0, arst_n = 0, wantRun = 0, pinN, zero = 0;
    logic ext = 0, uv = 0, hiLast;
    logic trimReg = 0, trimLow = 0, ovl = 0, ovc = 0, therm = 0, clip = 0;
    logic [3:0] hi, lo, pd;
    logic sdOut, sdOe, rdy, rdyF, clipO, oscO, oscOe, sw, busy;
    int miscompares = 0, cmpCount = 0, n, p;
    arc_reset_fault_ctrl dut (.clk(clk), .arst_n(arst_n),
        .reset_n_pin(pinN), .outMode(outMode), .trimToRegulator(trimReg),
        .trimLowFreq(trimLow), .oscSyncIn(ext), .overloadEvt(ovl),
        .overcurrentEvt(ovc), .thermalEvt(therm), .undervoltage(uv),
        .shortGndDet(zero), .shortPvddDet(zero), .clipDet(clip),
        .hbHighOn(hi), .hbLowOn(lo), .hbPulldown(pd),
        .faultShutdownOut(sdOut), .faultShutdownOe(sdOe), .readyOut(rdy),
        .readyFiltOut(rdyF), .clipOut(clipO), .oscSyncOut(oscO),
        .oscSyncOe(oscOe), .switching(sw), .shortCheckBusy(busy));
    arc_ctrl_model #(.HOLD(HOLD)) ctrl (.clk(clk), .faultOe(sdOe),
        .wantRun(wantRun), .pinN(pinN));
    // clock and watchdog
    initial forever #2.5 clk = ~clk;
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        complete_run();
    end
    // --------------------------------
    // helpers
    // --------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? sw : s == 1 ? pinN : s == 2 ? busy : oscO;
    endfunction
    task automatic waitOn(input int s, input logic v, input int lim);
        n = 0;
        while (pick(s) !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic tHeld();
        cyc(8);
        chk({hi, lo, pd, 4'(sdOe)}, 16'h00F0);
        @(posedge clk) outMode <= ARC_MODE_SINGLE;
        cyc(8);
        chk({hi, lo, pd, 4'(sdOe)}, 16'h0000);
        @(posedge clk) outMode <= ARC_MODE_PARALLEL;
        cyc(8);
        chk({hi, lo, pd, 4'(sdOe)}, 16'h00F0);
        $display("test held done");
    endtask
    task automatic tOsc();
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk) trimLow <= 1'(i);
            waitOn(3, 1'b0, 600);
            waitOn(3, 1'b1, 600);
            waitOn(3, 1'b0, 600);
            p = n;
            waitOn(3, 1'b1, 600);
            chk(16'(p + n), 16'(2 * (i ? `ARC_DIV_LOW : `ARC_DIV_NOMINAL)));
        end
        @(posedge clk) trimReg <= 1'b1;
        cyc(4);
        chk(oscOe, 1'b0);
        @(posedge clk) {trimReg, trimLow} <= 2'b00;
        cyc(4);
        $display("test oscillator done");
    endtask
    task automatic tStart();
        @(posedge clk) wantRun <= 1'b1;
        waitOn(1, 1'b1, 200);
        waitOn(2, 1'b1, 10);
        chk(16'(n >= 3 && n <= 4), 16'h0001);
        chk({pd, 2'(sdOe)}, 6'h01);
        @(posedge clk) wantRun <= 1'b0;
        cyc(20);
        chk({busy, sdOe}, 2'b11);
        @(posedge clk) wantRun <= 1'b1;
        waitOn(2, 1'b0, 2500);
        waitOn(0, 1'b1, 2100);
        chk(16'(n >= 1998 && n <= 2003), 16'h0001);
        cyc(20);
        chk({rdy, rdyF, sdOe}, 3'b110);
        $display("test start-up done");
    endtask
    task automatic tRun();
        @(posedge clk) clip <= 1'b1;
        cyc(3);
        chk(clipO, 1'b1);
        @(posedge clk) {clip, ovc} <= 2'b01;
        @(posedge clk) ovc <= 1'b0;
        #1;
        chk({clipO, rdy, rdyF}, 3'b000);
        cyc(1);
        chk({rdy, rdyF}, 2'b10);
        // slave mode: gates flip only on external clock rising edges
        @(posedge clk) trimReg <= 1'b1;
        cyc(2);
        hiLast = hi[0];
        cyc(4);
        chk({hi, lo}, {{4{hiLast}}, {4{~hiLast}}});
        @(posedge clk) ext <= 1'b1;
        cyc(1);
        chk({hi, lo}, {{4{~hiLast}}, {4{hiLast}}});
        @(posedge clk) ext <= 1'b0;
        cyc(2);
        chk({hi, lo}, {{4{~hiLast}}, {4{hiLast}}});
        @(posedge clk) trimReg <= 1'b0;
        // undervoltage shuts down, then recovers without reset
        @(posedge clk) uv <= 1'b1;
        cyc(3);
        chk({sdOe, sw, hi, lo}, 10'h200);
        @(posedge clk) uv <= 1'b0;
        cyc(2);
        chk({sdOe, sw, busy}, 3'b000);
        $display("test run status done");
    endtask
    task automatic tFault(input logic th);
        waitOn(0, 1'b1, 2500);
        @(posedge clk) {therm, ovl} <= th ? 2'b10 : 2'b01;
        @(posedge clk) {therm, ovl} <= 2'b00;
        cyc(3);
        chk({sdOe, sdOut, hi, lo}, 10'h200);
        cyc(200);
        chk({sdOe, sw}, 2'b10);
        @(posedge clk) wantRun <= 1'b0;
        cyc(8);
        chk({sdOe, pd}, 5'h0F);
        @(posedge clk) wantRun <= 1'b1;
        waitOn(0, 1'b1, 2400);
        chk({sw, busy}, 2'b10);
        $display("test fault done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        tHeld();
        tOsc();
        tStart();
        tRun();
        tFault(1'b1);
        tFault(1'b0);
        complete_run();
    end
endmodule // arc_reset_fault_ctrl_bench
`default_nettype wire
